// >>> hdl/psa_pkg.sv
// Package with constants and types for program space access addressing.
package psa_pkg;
  localparam int PSA_PC_W = 23;
  localparam int PSA_WORD_W = 24;
  localparam int PSA_DATA_W = 16;
  localparam int PSA_TPAGE_W = 8;
  localparam int PSA_RPAGE_W = 10;
  localparam int PSA_PADDR_W = 24;
  localparam logic [22:0] PSA_PC_RESET = 23'h00_0000;
  localparam logic [22:0] PSA_PC_STEP = 23'h00_0002;
  localparam logic [7:0] PSA_TPAGE_RESET = 8'h00;
  localparam logic [9:0] PSA_RPAGE_RESET = 10'h001;
  localparam logic [9:0] PSA_RPAGE_TRAP = 10'h000;
  localparam logic [9:0] PSA_RPAGE_PS_MIN = 10'h200;
  localparam logic [1:0] PSA_RPAGE_LSW = 2'h2;
  localparam logic [1:0] PSA_RPAGE_MSB = 2'h3;
  localparam int PSA_WIN_BIT = 15;
  // Flash regions: user and auxiliary.
  localparam logic PSA_REGION_USER = 1'b0;
  localparam logic PSA_REGION_AUX = 1'b1;
  localparam int PSA_AUX_SEL_BIT = 22;

  typedef enum logic [4:0] {
    PSA_OP_IDLE = 5'b00001,
    PSA_OP_FETCH = 5'b00010,
    PSA_OP_TABLE = 5'b00100,
    PSA_OP_WINDOW = 5'b01000,
    PSA_OP_TRAP = 5'b10000
  } psa_op_t;
endpackage

// >>> hdl/psa_mem_if.sv
// Interface bundling a program memory read port between modules.
`timescale 1ns/1ps
interface psa_mem_if;
  logic req;
  logic [22:0] word_addr;
  logic [23:0] rdata;
  logic valid;
  modport requester(output req, output word_addr, input rdata, input valid);
  modport responder(input req, input word_addr, output rdata, output valid);
endinterface

// >>> hdl/psa_lane_select.sv
// Byte lane selection for table and window reads of a 24-bit word.
`timescale 1ns/1ps
module psa_lane_select
  import psa_pkg::*;
(
  // Word and selection
  input wire logic [23:0] i_word,
  input wire logic i_high,
  input wire logic i_byte,
  input wire logic i_byte_sel,
  // Result
  output logic [15:0] o_data
);
  logic [15:0] half;
  always_comb begin
    // (RULE10) phantom byte zero
    half = i_high ? {8'h00, i_word[23:16]} : i_word[15:0];
    // (RULE9) byte lane select
    if (i_byte) begin
      o_data = i_byte_sel ? {8'h00, half[15:8]} : {8'h00, half[7:0]};
    end else begin
      o_data = half;
    end
  end
endmodule

// >>> hdl/psa_addr_gen.sv
// Program space address generation: fetch, table access and read window.
`timescale 1ns/1ps
// Summary of operation
// (RULE1) 4M x 24-bit space, 23-bit counter
// (RULE2) Counter steps by two, bit zero clear
// (RULE3) Byte select only for table, window
// (RULE4) Table page joins pointer into address
// (RULE5) Table page low eight bits, upper zero
// (RULE6) Read page ten bits, resets to 0x001
// (RULE7) Window read at page zero traps
// (RULE8) Low-word table access, word ignores LSb
// (RULE9) Byte low access picks lane by LSb
// (RULE10) High access upper byte, phantom reads zero
// (RULE11) Table writes fill write latches only
// (RULE12) Window address from 0x8000 plus page
// (RULE13) Windows of 32 Kbytes selectable
// (RULE14) Program window from page 0x200 up
// (RULE15) Window never writes program space
// (RULE16) Core loads read page by move
// (RULE17) Fetch other region during flash work
// (RULE18) Window program address from page, offset
// (RULE19) Page 9:8 picks low word or byte
// (RULE20) New page used by next access
module psa_addr_gen
  import psa_pkg::*;
(
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_arst_n,
  // Instruction fetch
  input wire logic i_fetch_step,
  input wire logic i_fetch_load,
  input wire logic [22:0] i_fetch_target,
  // Page register writes
  input wire logic i_tpage_we,
  input wire logic i_rpage_we,
  input wire logic [15:0] i_page_wdata,
  // Table access
  input wire logic i_tbl_req,
  input wire logic i_tbl_write,
  input wire logic i_tbl_high,
  input wire logic i_tbl_byte,
  input wire logic [15:0] i_tbl_ptr,
  input wire logic [15:0] i_tbl_wdata,
  // Data window read
  input wire logic i_win_req,
  input wire logic i_win_byte,
  input wire logic [15:0] i_win_ea,
  // Flash state and memory
  input wire logic i_user_busy,
  input wire logic i_aux_busy,
  input wire logic [23:0] i_mem_rdata,
  // Core side results
  output logic [22:0] o_pc,
  output logic [15:0] o_table_page,
  output logic [15:0] o_window_read_page,
  output logic o_rd_valid,
  output logic [15:0] o_rd_data,
  output logic o_addr_trap,
  output logic o_ds_read,
  output logic [23:0] o_ds_addr,
  output logic o_fetch_stall,
  // Memory side
  output logic o_mem_req,
  output logic [23:0] o_mem_addr,
  output logic o_latch_we,
  output logic [23:0] o_latch_addr,
  output logic [15:0] o_latch_data,
  output logic [1:0] o_latch_lanes
);
  logic [22:0] pc;
  logic [7:0] tpage;
  logic [9:0] rpage;
  logic rd_high;
  logic rd_byte;
  logic rd_sel;
  logic rd_pend;
  logic [15:0] lane_data;
  psa_op_t op;

  function automatic logic region_of(input logic [22:0] a);
    region_of = a[PSA_AUX_SEL_BIT] ? PSA_REGION_AUX : PSA_REGION_USER;
  endfunction

  // (RULE4) table address join
  function automatic logic [23:0] tbl_addr(input logic [7:0] pg, input logic [15:0] p);
    tbl_addr = {pg, p};
  endfunction

  // The bundle mirrors the registered request so that every member of it has a driver.
  psa_mem_if mem ();
  assign mem.req = o_mem_req;
  assign mem.word_addr = o_mem_addr[23:1];
  assign mem.rdata = i_mem_rdata;
  assign mem.valid = rd_pend;

  psa_lane_select u_lane (
    .i_word(mem.rdata),
    .i_high(rd_high),
    .i_byte(rd_byte),
    .i_byte_sel(rd_sel),
    .o_data(lane_data)
  );

  // A fetch only stalls when its own region is busy; the other region keeps running.
  logic fetch_blocked;
  always_comb begin
    // (RULE17) region independent fetch
    fetch_blocked = (region_of(pc) == PSA_REGION_USER) ? i_user_busy : i_aux_busy;
  end

  // (RULE2) program counter step
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pc <= PSA_PC_RESET;
    end else if (i_fetch_load) begin
      // (RULE3) fetch LSb forced zero
      pc <= {i_fetch_target[22:1], 1'b0};
    end else if (i_fetch_step && !fetch_blocked) begin
      pc <= pc + PSA_PC_STEP;
    end
  end

  // (RULE5) table page storage
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      tpage <= PSA_TPAGE_RESET;
    end else if (i_tpage_we) begin
      tpage <= i_page_wdata[7:0];
    end
  end

  // (RULE6) read page storage
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rpage <= PSA_RPAGE_RESET;
    end else if (i_rpage_we) begin
      rpage <= i_page_wdata[9:0];
    end
  end

  // Register reads; upper bits are unimplemented.
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_table_page <= {8'h00, PSA_TPAGE_RESET};
      o_window_read_page <= {6'h00, PSA_RPAGE_RESET};
      o_pc <= PSA_PC_RESET;
    end else begin
      o_table_page <= {8'h00, tpage};
      o_window_read_page <= {6'h00, rpage};
      o_pc <= pc;
    end
  end

  // Request decode; window has priority below table, fetch below both on the same memory port.
  always_comb begin
    op = PSA_OP_IDLE;
    if (i_tbl_req) begin
      op = PSA_OP_TABLE;
    end else if (i_win_req && i_win_ea[PSA_WIN_BIT]) begin
      // (RULE7) page zero trap
      if (rpage == PSA_RPAGE_TRAP) begin
        op = PSA_OP_TRAP;
      end else begin
        op = PSA_OP_WINDOW;
      end
    end else if (i_fetch_step && !fetch_blocked) begin
      op = PSA_OP_FETCH;
    end
  end

  // Memory request and read steering; page registers are used as stored (RULE20 below).
  // (RULE20) current page used
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_mem_req <= 1'b0;
      o_mem_addr <= 24'h00_0000;
      rd_pend <= 1'b0;
      rd_high <= 1'b0;
      rd_byte <= 1'b0;
      rd_sel <= 1'b0;
      o_addr_trap <= 1'b0;
      o_ds_read <= 1'b0;
      o_ds_addr <= 24'h00_0000;
      o_fetch_stall <= 1'b0;
    end else begin
      o_mem_req <= 1'b0;
      rd_pend <= 1'b0;
      o_addr_trap <= 1'b0;
      o_ds_read <= 1'b0;
      o_fetch_stall <= i_fetch_step && fetch_blocked;
      case (op)
        PSA_OP_FETCH: begin
          // (RULE1) 23-bit fetch address
          o_mem_req <= 1'b1;
          o_mem_addr <= {1'b0, pc[22:1], 1'b0};
        end
        PSA_OP_TABLE: begin
          if (!i_tbl_write) begin
            o_mem_req <= 1'b1;
            // (RULE8) word ignores LSb
            o_mem_addr <= tbl_addr(tpage, {i_tbl_ptr[15:1], 1'b0});
            rd_pend <= 1'b1;
            rd_high <= i_tbl_high;
            rd_byte <= i_tbl_byte;
            rd_sel <= i_tbl_ptr[0];
          end
        end
        PSA_OP_WINDOW: begin
          // (RULE14) program or data page
          if (rpage >= PSA_RPAGE_PS_MIN) begin
            o_mem_req <= 1'b1;
            // (RULE18) window program address
            o_mem_addr <= {1'b0, rpage[7:0], i_win_ea[14:1], 1'b0};
            rd_pend <= 1'b1;
            // (RULE19) low word or upper byte
            rd_high <= (rpage[9:8] == PSA_RPAGE_MSB);
            rd_byte <= i_win_byte || (rpage[9:8] == PSA_RPAGE_MSB);
            rd_sel <= (rpage[9:8] == PSA_RPAGE_MSB) ? 1'b0 : i_win_ea[0];
          end else begin
            // (RULE12) data page window
            o_ds_read <= 1'b1;
            // (RULE13) 32 Kbyte window
            o_ds_addr <= {rpage[8:0], i_win_ea[14:0]};
          end
        end
        PSA_OP_TRAP: begin
          o_addr_trap <= 1'b1;
        end
        PSA_OP_IDLE: begin
          o_mem_req <= 1'b0;
        end
        default: begin
          o_mem_req <= 1'b0;
        end
      endcase
    end
  end

  // Read data returns one cycle after the memory request.
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_rd_valid <= 1'b0;
      o_rd_data <= 16'h0000;
    end else begin
      o_rd_valid <= mem.valid;
      if (mem.valid) begin
        o_rd_data <= lane_data;
      end
    end
  end

  // (RULE11) table write to latches
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_latch_we <= 1'b0;
      o_latch_addr <= 24'h00_0000;
      o_latch_data <= 16'h0000;
      o_latch_lanes <= 2'b00;
    end else begin
      o_latch_we <= (op == PSA_OP_TABLE) && i_tbl_write;
      if ((op == PSA_OP_TABLE) && i_tbl_write) begin
        o_latch_addr <= {tpage, i_tbl_ptr[15:1], i_tbl_high};
        o_latch_data <= i_tbl_byte ? {2{i_tbl_wdata[7:0]}} : i_tbl_wdata;
        o_latch_lanes <= !i_tbl_byte ? 2'b11 : (i_tbl_ptr[0] ? 2'b10 : 2'b01);
      end
    end
  end

  // (RULE15) no window write path exists; window is read only by construction.

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_arst_n);

  a_pc_even: assert property (o_pc[0] == 1'b0) else $error("pc lsb set"); // (RULE3)
  a_pc_step: assert property (i_fetch_step && !fetch_blocked && !i_fetch_load // (RULE2)
    |=> pc == $past(pc) + PSA_PC_STEP) else $error("pc step wrong");
  a_trap_zero: assert property (i_win_req && i_win_ea[15] && !i_tbl_req // (RULE7)
    && rpage == PSA_RPAGE_TRAP |=> o_addr_trap && !o_mem_req) else $error("no trap");
  a_tpage_upper: assert property (o_table_page[15:8] == 8'h00) else $error("tpage hi"); // (RULE5)
  a_rpage_upper: assert property (o_window_read_page[15:10] == 6'h00) // (RULE6)
    else $error("rpage hi");
  a_tbl_addr: assert property (i_tbl_req && !i_tbl_write // (RULE4)
    |=> o_mem_req && o_mem_addr[23:16] == $past(tpage)) else $error("tbl addr");
  a_hi_phantom: assert property (rd_pend && rd_high |=> o_rd_data[15:8] == 8'h00) // (RULE10)
    else $error("phantom");
  a_write_latch: assert property (i_tbl_req && i_tbl_write |=> o_latch_we && !o_mem_req) // (RULE11)
    else $error("latch");
  a_win_ps: assert property (op == PSA_OP_WINDOW && rpage < PSA_RPAGE_PS_MIN // (RULE14)
    |=> !o_mem_req && o_ds_read) else $error("win ds");
  a_win_addr: assert property (op == PSA_OP_WINDOW && rpage >= PSA_RPAGE_PS_MIN // (RULE18)
    |=> o_mem_addr[23] == 1'b0) else $error("win msb");
  a_win_nowrite: assert property (i_win_req && !i_tbl_req |=> !o_latch_we) // (RULE15)
    else $error("window wrote latch");
  a_ds_addr: assert property (op == PSA_OP_WINDOW && rpage < PSA_RPAGE_PS_MIN // (RULE12)
    |=> {1'b1, o_ds_addr[14:0]} == $past(i_win_ea)) else $error("ds addr");
  a_lsw_lane: assert property (op == PSA_OP_WINDOW && rpage[9:8] == PSA_RPAGE_LSW // (RULE19)
    && !i_win_byte |=> !rd_high && !rd_byte) else $error("lsw lane");
  a_fetch_free: assert property (i_fetch_step && !pc[22] && !i_user_busy // (RULE17)
    |=> !o_fetch_stall) else $error("fetch stalled");
  a_fetch_addr: assert property (op == PSA_OP_FETCH // (RULE3)
    |=> o_mem_addr[0] == 1'b0 && o_mem_addr[23] == 1'b0) else $error("fetch addr");
  c_trap: cover property (o_addr_trap);
  c_tbl_read: cover property (o_rd_valid && !rd_high);
  c_win_ps: cover property (op == PSA_OP_WINDOW && rpage >= 10'h300);
  c_stall: cover property (o_fetch_stall);
  c_latch_byte: cover property (o_latch_we && o_latch_lanes != 2'b11);
endmodule

// >>> tb/psa_mem_model.sv
// Behavioural program memory that answers the address generator.
`timescale 1ns/1ps
module psa_mem_model (
  // Clock and request
  input wire logic i_clock,
  input wire logic i_req,
  input wire logic [23:0] i_addr,
  // Word returned
  output logic [23:0] o_rdata
);
  logic junk = 1'b0;
  // An idle port toggles every cycle so that stale data can never pass for a match.
  always @(posedge i_clock) begin
    junk <= ~junk;
  end
  assign o_rdata = i_req ? {i_addr[23:16] ^ 8'h3C, i_addr[15:0] ^ 16'hA5C3} : {24{junk}};
endmodule

// >>> tb/testbench.sv
// Self-checking bench for the program space address generator.
`timescale 1ns/1ps
module testbench;
  import psa_pkg::*;
  logic i_clock = 1'b0;
  logic i_arst_n = 1'b0;
  logic fs = 1'b0, fl = 1'b0, twe = 1'b0, rwe = 1'b0, treq = 1'b0, twr = 1'b0;
  logic thi = 1'b0, tby = 1'b0, wreq = 1'b0, wby = 1'b0, ubusy = 1'b0, abusy = 1'b0;
  logic [22:0] ft = 23'h00_0000;
  logic [15:0] pwd = 16'h0000, tptr = 16'h0000, twd = 16'h0000, wea = 16'h0000;
  logic [23:0] mrd, maddr, dsa, laddr;
  logic [22:0] pc;
  logic [1:0] llan;
  logic [15:0] tpg, rpg, rdd, ldat;
  logic rdv, trap, dsr, stall, mreq, lwe;
  int n_errors = 0;
  int comparisons = 0;

  always #5 i_clock = ~i_clock;

  psa_addr_gen DUT (.i_clock(i_clock), .i_arst_n(i_arst_n), .i_fetch_step(fs),
    .i_fetch_load(fl), .i_fetch_target(ft), .i_tpage_we(twe), .i_rpage_we(rwe),
    .i_page_wdata(pwd), .i_tbl_req(treq), .i_tbl_write(twr), .i_tbl_high(thi),
    .i_tbl_byte(tby), .i_tbl_ptr(tptr), .i_tbl_wdata(twd), .i_win_req(wreq),
    .i_win_byte(wby), .i_win_ea(wea), .i_user_busy(ubusy), .i_aux_busy(abusy),
    .i_mem_rdata(mrd), .o_pc(pc), .o_table_page(tpg), .o_window_read_page(rpg),
    .o_rd_valid(rdv), .o_rd_data(rdd), .o_addr_trap(trap), .o_ds_read(dsr),
    .o_ds_addr(dsa), .o_fetch_stall(stall), .o_mem_req(mreq), .o_mem_addr(maddr),
    .o_latch_we(lwe), .o_latch_addr(laddr), .o_latch_data(ldat), .o_latch_lanes(llan));
  psa_mem_model mem (.i_clock(i_clock), .i_req(mreq), .i_addr(maddr), .o_rdata(mrd));

  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    comparisons++;
    if (!(got === exp)) begin
      n_errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chb(input logic got, input logic exp);
    chk({23'h00_0000, got}, {23'h00_0000, exp});
  endtask

  task automatic tally_and_finish;
    $display("comparisons=%0d n_errors=%0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic page(input logic r, input logic [15:0] v);
    @(posedge i_clock);
    rwe <= r;
    twe <= !r;
    pwd <= v;
    @(posedge i_clock);
    rwe <= 1'b0;
    twe <= 1'b0;
    @(posedge i_clock);
    #1;
  endtask

  // Returns just after the edge that took the request, with the answer standing.
  task automatic acc(input logic w, wr, hi, by, input logic [15:0] p, d);
    @(posedge i_clock);
    treq <= !w;
    wreq <= w;
    twr <= wr;
    thi <= hi;
    tby <= by;
    wby <= by;
    tptr <= p;
    wea <= p;
    twd <= d;
    @(posedge i_clock);
    treq <= 1'b0;
    wreq <= 1'b0;
    #1;
  endtask

  task automatic next_read(input logic [23:0] exp);
    @(posedge i_clock);
    #1;
    chb(rdv, 1'b1);
    chk({8'h00, rdd}, exp);
  endtask

  task automatic t_pages;
    chk({8'h00, tpg}, 24'h00_0000);
    chk({8'h00, rpg}, 24'h00_0001);
    chk({1'b0, pc}, 24'h00_0000);
    page(1'b0, 16'hFFAB);
    chk({8'h00, tpg}, 24'h00_00AB);
    page(1'b1, 16'hFFFF);
    chk({8'h00, rpg}, 24'h00_03FF);
  endtask

  task automatic t_table;
    acc(1'b0, 1'b0, 1'b0, 1'b0, 16'h1235, 16'h0000);
    chb(mreq, 1'b1);
    chk(maddr, 24'hAB_1234);
    next_read(24'h00_B7F7);
    acc(1'b0, 1'b0, 1'b0, 1'b1, 16'h1235, 16'h0000);
    next_read(24'h00_00B7);
    acc(1'b0, 1'b0, 1'b1, 1'b0, 16'h1234, 16'h0000);
    next_read(24'h00_0097);
    acc(1'b0, 1'b0, 1'b1, 1'b1, 16'h1235, 16'h0000);
    next_read(24'h00_0000);
    acc(1'b0, 1'b1, 1'b0, 1'b0, 16'h1235, 16'h1357);
    chb(lwe, 1'b1);
    chk(laddr, 24'hAB_1234);
    chk({8'h00, ldat}, 24'h00_1357);
    chk({22'h00_0000, llan}, 24'h00_0003);
    chb(mreq, 1'b0);
    acc(1'b0, 1'b1, 1'b1, 1'b1, 16'h1235, 16'h0057);
    chb(lwe, 1'b1);
    chk(laddr, 24'hAB_1235);
    chk({8'h00, ldat}, 24'h00_5757);
    chk({22'h00_0000, llan}, 24'h00_0002);
  endtask

  task automatic t_window;
    page(1'b1, 16'h02C5);
    acc(1'b1, 1'b0, 1'b0, 1'b0, 16'h9234, 16'h0000);
    chk(maddr, 24'h62_9234);
    next_read(24'h00_37F7);
    page(1'b1, 16'h03C5);
    acc(1'b1, 1'b0, 1'b0, 1'b0, 16'h9234, 16'h0000);
    next_read(24'h00_005E);
    page(1'b1, 16'h0005);
    acc(1'b1, 1'b0, 1'b0, 1'b0, 16'h8ABC, 16'h0000);
    chb(dsr, 1'b1);
    chb(mreq, 1'b0);
    chk(dsa, 24'h02_8ABC);
    page(1'b1, 16'h0000);
    acc(1'b1, 1'b0, 1'b0, 1'b0, 16'h8000, 16'h0000);
    chb(trap, 1'b1);
    @(posedge i_clock);
    #1;
    chb(rdv, 1'b0);
  endtask

  task automatic t_fetch;
    @(posedge i_clock);
    fl <= 1'b1;
    ft <= 23'h00_1235;
    abusy <= 1'b1;
    @(posedge i_clock);
    fl <= 1'b0;
    fs <= 1'b1;
    @(posedge i_clock);
    fs <= 1'b0;
    @(posedge i_clock);
    #1;
    chk({1'b0, pc}, 24'h00_1236);
    chk(maddr, 24'h00_1234);
    @(posedge i_clock);
    ubusy <= 1'b1;
    fs <= 1'b1;
    repeat (2) @(posedge i_clock);
    #1;
    chb(stall, 1'b1);
    chk({1'b0, pc}, 24'h00_1236);
  endtask

  initial begin
    repeat (12) @(posedge i_clock);
    i_arst_n <= 1'b1;
    #1;
    t_pages();
    t_table();
    t_window();
    t_fetch();
    tally_and_finish();
  end

  // The whole sequence needs under a hundred cycles; this bound is far beyond it.
  initial begin
    #100000;
    n_errors++;
    tally_and_finish();
  end
endmodule
